// >>> hw/fifo_track_pkg.sv
// constants shared by the packet fifo level tracking block
package fifo_track_pkg;

  // register byte offsets
  localparam logic [11:0] OFF_DELAY = 12'h06c;
  localparam logic [11:0] OFF_RX_LVL = 12'h070;
  localparam logic [11:0] OFF_RX_PTR = 12'h074;
  localparam logic [11:0] OFF_TX_LVL = 12'h078;

  // short packet delay field
  localparam int DELAY_W = 16;
  localparam logic [15:0] DELAY_RESET = 16'h0800;

  // status field positions
  localparam int RD_FIELD_LSB = 16;
  localparam int WR_FIELD_LSB = 0;

  // timing: pclk period and the delay unit (16.667 ns), both in ps
  localparam int CLK_PERIOD_PS = 8000;
  localparam int UNIT_TIME_PS = 16667;
  localparam int TICK_ACC_W = 15;

  typedef enum logic [1:0] {
    DLY_IDLE = 2'b00,
    DLY_WAIT = 2'b01,
    DLY_DONE = 2'b10
  } delay_state_t;

endpackage

// >>> hw/packet_fifo_level_tracking.sv
// level bookkeeping for the rx and tx packet fifos, rx fifo pointers and the short-packet delay
`timescale 1ns/100ps
`default_nettype none

module packet_fifo_level_tracking #(
  parameter int RX_AW = 13,
  parameter int TX_AW = 11
) (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // rx fifo write side (mac)
  input wire logic rx_wr_valid,
  input wire logic [31:0] rx_wr_data,
  input wire logic rx_wr_last,
  input wire logic rx_fcs_bad,
  output logic rx_wr_ready,
  // rx fifo read side (usb)
  output logic rx_rd_valid,
  output logic [31:0] rx_rd_data,
  output logic rx_rd_last,
  input wire logic rx_rd_ready,
  input wire logic usb_rewind,
  // tx fifo events
  input wire logic tx_wr_dword,
  input wire logic tx_wr_last,
  input wire logic tx_wr_rewind,
  input wire logic tx_rd_dword,
  input wire logic tx_rd_last,
  // short packet handshake with the usb transmitter
  input wire logic short_req,
  output logic short_go
);
  import fifo_track_pkg::*;

  localparam int RXL = RX_AW + 1;
  localparam int TXL = TX_AW + 1;
  localparam logic [RXL-1:0] RX_DEPTH = RXL'(1 << RX_AW);

  function automatic logic [RXL-1:0] lvl(input logic [RXL-1:0] cur, input logic [RXL-1:0] add,
                                         input logic [RXL-1:0] sub);
    return cur + add - sub;
  endfunction

  function automatic logic [TXL-1:0] tx_lvl(input logic [TXL-1:0] cur, input logic [TXL-1:0] add,
                                            input logic [TXL-1:0] sub);
    return cur + add - sub;
  endfunction

  logic [DELAY_W-1:0] short_packet_delay;
  logic [RXL-1:0] rx_read_level;
  logic [RXL-1:0] rx_write_level;
  logic [RX_AW-1:0] rx_read_pointer;
  logic [RX_AW-1:0] rx_write_pointer;
  logic [TXL-1:0] tx_read_level;
  logic [TXL-1:0] tx_write_level;
  logic [31:0] rx_level_status;
  logic [31:0] rx_pointer_status;
  logic [31:0] tx_level_status;

  logic [32:0] rx_mem [0:(1 << RX_AW)-1];
  logic [RX_AW-1:0] rx_wr_start;
  logic [RXL-1:0] rx_wr_cnt;
  logic rx_wr_fire;
  logic rx_wr_done;
  // a failing frame must not sneak a word in on the rewind cycle
  assign rx_wr_ready = (rx_write_level < RX_DEPTH) && !rx_fcs_bad;
  assign rx_wr_fire = rx_wr_valid && rx_wr_ready;
  assign rx_wr_done = rx_wr_fire && rx_wr_last;

  always_ff @(posedge pclk) begin
    if (rx_wr_fire) begin
      rx_mem[rx_write_pointer] <= {rx_wr_last, rx_wr_data};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_write_pointer <= '0;
      rx_wr_start <= '0;
      rx_wr_cnt <= '0;
    end else if (rx_fcs_bad) begin
      rx_write_pointer <= rx_wr_start;
      rx_wr_cnt <= '0;
    end else if (rx_wr_fire) begin
      rx_write_pointer <= rx_write_pointer + 1'b1;
      if (rx_wr_last) begin
        rx_wr_start <= rx_write_pointer + 1'b1;
        rx_wr_cnt <= '0;
      end else begin
        rx_wr_cnt <= rx_wr_cnt + 1'b1;
      end
    end
  end

  logic [RX_AW-1:0] rx_rd_start;
  logic [RXL-1:0] rx_rd_cnt;
  logic [32:0] mem_word;
  logic pop;
  logic pop_last;
  logic pull;
  logic [1:0] buf_cnt;
  logic buf_head;
  logic [31:0] buf_data [0:1];
  logic buf_last [0:1];
  logic buf_slot;
  assign mem_word = rx_mem[rx_read_pointer];
  // only complete packets are visible, so a pop never runs past the writer
  assign pop = (rx_read_level != '0) && (buf_cnt != 2'd2) && !usb_rewind;
  assign pop_last = pop && mem_word[32];
  assign pull = rx_rd_valid && rx_rd_ready;
  assign buf_slot = buf_head ^ buf_cnt[0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_read_pointer <= '0;
      rx_rd_start <= '0;
      rx_rd_cnt <= '0;
    end else if (usb_rewind) begin
      rx_read_pointer <= rx_rd_start;
      rx_rd_cnt <= '0;
    end else if (pop) begin
      rx_read_pointer <= rx_read_pointer + 1'b1;
      if (mem_word[32]) begin
        rx_rd_start <= rx_read_pointer + 1'b1;
        rx_rd_cnt <= '0;
      end else begin
        rx_rd_cnt <= rx_rd_cnt + 1'b1;
      end
    end
  end

  // two-entry buffer: a stall by the usb side only blocks further pops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_cnt <= '0;
      buf_head <= 1'b0;
    end else if (usb_rewind) begin
      buf_cnt <= '0;
      buf_head <= 1'b0;
    end else begin
      buf_cnt <= buf_cnt + {1'b0, pop} - {1'b0, pull};
      buf_head <= buf_head ^ pull;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_data[0] <= '0;
      buf_data[1] <= '0;
      buf_last[0] <= 1'b0;
      buf_last[1] <= 1'b0;
    end else if (pop) begin
      buf_data[buf_slot] <= mem_word[31:0];
      buf_last[buf_slot] <= mem_word[32];
    end
  end

  assign rx_rd_valid = buf_cnt != 2'd0;
  assign rx_rd_data = buf_data[buf_head];
  assign rx_rd_last = buf_last[buf_head];

  // a word counts as read when it leaves the store, so buffered words are restored by a rewind;
  // once a packet's last word has left the store it can no longer be rewound.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_read_level <= '0;
      rx_write_level <= '0;
    end else begin
      rx_read_level <= lvl(rx_read_level,
                           (rx_wr_done ? rx_wr_cnt + 1'b1 : '0)
                           + (usb_rewind ? rx_rd_cnt : '0),
                           pop ? RXL'(1) : '0);
      rx_write_level <= lvl(rx_write_level,
                            rx_wr_fire ? RXL'(1) : '0,
                            (pop_last ? rx_rd_cnt + 1'b1 : '0)
                            + (rx_fcs_bad ? rx_wr_cnt : '0));
    end
  end

  logic [TXL-1:0] tx_wr_cnt;
  logic [TXL-1:0] tx_rd_cnt;
  logic tx_wr_inc;
  // a dword that arrives with the rewind belongs to the bad packet
  assign tx_wr_inc = tx_wr_dword && !tx_wr_rewind;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_wr_cnt <= '0;
    end else if (tx_wr_rewind) begin
      tx_wr_cnt <= '0;
    end else if (tx_wr_dword) begin
      tx_wr_cnt <= tx_wr_last ? '0 : tx_wr_cnt + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_rd_cnt <= '0;
    end else if (tx_rd_dword) begin
      tx_rd_cnt <= tx_rd_last ? '0 : tx_rd_cnt + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_read_level <= '0;
      tx_write_level <= '0;
    end else begin
      // no rewind term on the read level
      tx_read_level <= tx_lvl(tx_read_level,
                              (tx_wr_inc && tx_wr_last) ? tx_wr_cnt + 1'b1 : '0,
                              tx_rd_dword ? TXL'(1) : '0);
      tx_write_level <= tx_lvl(tx_write_level,
                               tx_wr_inc ? TXL'(1) : '0,
                               ((tx_rd_dword && tx_rd_last) ? tx_rd_cnt + 1'b1 : '0)
                               + (tx_wr_rewind ? tx_wr_cnt : '0));
    end
  end

  logic [TICK_ACC_W-1:0] tick_acc;
  logic [TICK_ACC_W-1:0] tick_sum;
  logic tick;
  logic [DELAY_W-1:0] dly_cnt;
  delay_state_t dly_state;
  // fractional divider: one tick per unit time on average, no second clock
  assign tick_sum = tick_acc + TICK_ACC_W'(CLK_PERIOD_PS);
  assign tick = tick_sum >= TICK_ACC_W'(UNIT_TIME_PS);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_acc <= '0;
    end else begin
      tick_acc <= tick ? tick_sum - TICK_ACC_W'(UNIT_TIME_PS) : tick_sum;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dly_state <= DLY_IDLE;
      dly_cnt <= '0;
      short_go <= 1'b0;
    end else begin
      short_go <= 1'b0;
      unique case (dly_state)
        DLY_IDLE: begin
          dly_cnt <= '0;
          if (short_req) begin
            dly_state <= DLY_WAIT;
          end
        end
        DLY_WAIT: begin
          if (!short_req) begin
            dly_state <= DLY_IDLE;
          end else if (dly_cnt >= short_packet_delay) begin
            short_go <= 1'b1;
            dly_state <= DLY_DONE;
          end else if (tick) begin
            dly_cnt <= dly_cnt + 1'b1;
          end
        end
        DLY_DONE: begin
          if (!short_req) begin
            dly_state <= DLY_IDLE;
          end
        end
        default: begin
          dly_state <= DLY_IDLE;
        end
      endcase
    end
  end

  always_comb begin
    rx_level_status = '0;
    rx_level_status[RD_FIELD_LSB +: RXL] = rx_read_level;
    rx_level_status[WR_FIELD_LSB +: RXL] = rx_write_level;
    rx_pointer_status = '0;
    rx_pointer_status[RD_FIELD_LSB +: RX_AW] = rx_read_pointer;
    rx_pointer_status[WR_FIELD_LSB +: RX_AW] = rx_write_pointer;
    tx_level_status = '0;
    tx_level_status[RD_FIELD_LSB +: TXL] = tx_read_level;
    tx_level_status[WR_FIELD_LSB +: TXL] = tx_write_level;
  end

  logic apb_setup;
  logic apb_write;
  assign apb_setup = psel && !penable;
  assign apb_write = psel && penable && pwrite;
  // read data is captured in the setup cycle, so no wait state is needed
  assign pready = 1'b1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pslverr <= 1'b0;
    end else if (apb_setup) begin
      pslverr <= 1'b0;
      unique case (paddr)
        OFF_DELAY: prdata <= {{(32 - DELAY_W){1'b0}}, short_packet_delay};
        OFF_RX_LVL: prdata <= rx_level_status;
        OFF_RX_PTR: prdata <= rx_pointer_status;
        OFF_TX_LVL: prdata <= tx_level_status;
        default: begin
          prdata <= '0;
          pslverr <= 1'b1;
        end
      endcase
    end
  end

  // writes to the status words are dropped without error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      short_packet_delay <= DELAY_RESET;
    end else if (apb_write && paddr == OFF_DELAY) begin
      if (pstrb[0]) begin
        short_packet_delay[7:0] <= pwdata[7:0];
      end
      if (pstrb[1]) begin
        short_packet_delay[15:8] <= pwdata[15:8];
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  rx_read_pkt_a: assert property (rx_wr_done && !pop && !usb_rewind
    |=> rx_read_level == $past(rx_read_level) + $past(rx_wr_cnt) + 1'b1)
    else $error("rx read level missed a stored packet");
  rx_read_pop_a: assert property (pop && !rx_wr_done |=> rx_read_level == $past(rx_read_level) - 1'b1)
    else $error("rx read level did not drop on a read");
  rx_rewind_a: assert property (usb_rewind && !rx_wr_done |=>
    rx_read_level == $past(rx_read_level) + $past(rx_rd_cnt) && rx_read_pointer == $past(rx_rd_start))
    else $error("rx read rewind restored the wrong amount");
  rx_rewind_buf_a: assert property (usb_rewind |=> !rx_rd_valid && rx_read_pointer == $past(rx_rd_start))
    else $error("rx read rewind did not restart the packet");
  tx_no_rewind_a: assert property (!tx_rd_dword && !(tx_wr_inc && tx_wr_last) |=> $stable(tx_read_level))
    else $error("tx read level moved without cause");
  rx_write_inc_a: assert property (rx_wr_fire && !pop_last |=> rx_write_level == $past(rx_write_level) + 1'b1)
    else $error("rx write level did not count a write");
  rx_write_drop_a: assert property (pop_last && !rx_wr_fire && !rx_fcs_bad
    |=> rx_write_level == $past(rx_write_level) - $past(rx_rd_cnt) - 1'b1)
    else $error("rx write level wrong after packet read");
  rx_fcs_rewind_a: assert property (rx_fcs_bad && !pop_last
    |=> rx_write_level == $past(rx_write_level) - $past(rx_wr_cnt) && rx_write_pointer == $past(rx_wr_start))
    else $error("rx frame discard wrong");
  tx_wr_rewind_a: assert property (tx_wr_rewind && !tx_rd_dword
    |=> tx_write_level == $past(tx_write_level) - $past(tx_wr_cnt))
    else $error("tx write rewind wrong");
  rx_level_map_a: assert property (apb_setup && paddr == OFF_RX_LVL
    |=> prdata[29:16] == $past(rx_read_level) && prdata[13:0] == $past(rx_write_level) && prdata[31:30] == 2'b00)
    else $error("rx level status layout wrong");
  tx_level_map_a: assert property (apb_setup && paddr == OFF_TX_LVL
    |=> prdata[27:16] == $past(tx_read_level) && prdata[31:28] == 4'h0)
    else $error("tx level status layout wrong");
  rx_ptr_map_a: assert property (apb_setup && paddr == OFF_RX_PTR |=> prdata[12:0] == $past(rx_write_pointer))
    else $error("rx pointer status layout wrong");
  status_ro_a: assert property (apb_write && paddr != OFF_DELAY |=> $stable(short_packet_delay))
    else $error("status write changed the delay");
  short_go_a: assert property (short_go |-> $past(dly_cnt) >= $past(short_packet_delay) && $past(short_req))
    else $error("short packet released early");
  tick_rate_a: assert property (tick |=> !tick)
    else $error("delay tick faster than the unit");
  fcs_cover: cover property (rx_fcs_bad && rx_wr_cnt != '0);
  rewind_cover: cover property (usb_rewind && rx_rd_cnt != '0);
  full_buf_cover: cover property (buf_cnt == 2'd2 && !rx_rd_ready);
  short_cover: cover property (short_go);

endmodule

`default_nettype wire

// >>> tb/mac_usb_model.sv
// partner model: mac writing the rx fifo and usb transmitter reading it
`timescale 1ns/100ps
`default_nettype none
module mac_usb_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // mac write side
  output logic rx_wr_valid,
  output logic [31:0] rx_wr_data,
  output logic rx_wr_last,
  input wire logic rx_wr_ready,
  // usb read side
  input wire logic rx_rd_valid,
  input wire logic [31:0] rx_rd_data,
  input wire logic rx_rd_last,
  output logic rx_rd_ready,
  input wire logic usb_stall
);
  logic [32:0] got[$];
  initial begin
    rx_wr_valid = 1'b0;
    rx_wr_data = 32'h0000_0000;
    rx_wr_last = 1'b0;
    rx_rd_ready = 1'b0;
  end
  // taken words are logged with their last flag
  always @(posedge pclk) begin
    rx_rd_ready <= presetn & ~usb_stall;
    if (rx_rd_valid && rx_rd_ready) got.push_back({rx_rd_last, rx_rd_data});
  end
  // one word per beat, held until taken
  task automatic send(input int n, input logic ends);
    for (int i = 0; i < n; i++) begin
      rx_wr_valid <= 1'b1;
      rx_wr_data <= 32'hc0de_0000 + 32'(i);
      rx_wr_last <= ends && (i == n - 1);
      do @(posedge pclk); while (rx_wr_ready !== 1'b1);
    end
    rx_wr_valid <= 1'b0;
    // a released data line must not keep showing the last word
    rx_wr_data <= ~rx_wr_data;
    rx_wr_last <= 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> tb/tb.sv
// self-checking bench for the packet fifo level tracking block
`timescale 1ns/100ps
`default_nettype none
module tb;
  import fifo_track_pkg::*;
  typedef struct {logic wr; logic [11:0] a; logic [31:0] d; logic [31:0] rd; logic err;} row_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rx_wr_data, rx_rd_data;
  logic rx_wr_valid, rx_wr_last, rx_fcs_bad, rx_wr_ready, rx_rd_valid, rx_rd_last, rx_rd_ready;
  logic usb_rewind, usb_stall, short_req, short_go;
  logic tx_wr_dword, tx_wr_last, tx_wr_rewind, tx_rd_dword, tx_rd_last;
  int mismatches = 0;
  int total_checks = 0;
  int cyc = 0;
  row_t rows[9] = '{
    '{1'b0, OFF_DELAY, 32'h0000_0000, 32'h0000_0800, 1'b0},
    '{1'b0, OFF_RX_LVL, 32'h0000_0000, 32'h0000_0000, 1'b0},
    '{1'b0, OFF_RX_PTR, 32'h0000_0000, 32'h0000_0000, 1'b0},
    '{1'b0, OFF_TX_LVL, 32'h0000_0000, 32'h0000_0000, 1'b0},
    '{1'b1, OFF_TX_LVL, 32'hffff_ffff, 32'h0000_0000, 1'b0},
    '{1'b0, OFF_TX_LVL, 32'h0000_0000, 32'h0000_0000, 1'b0},
    '{1'b0, 12'h07c, 32'h0000_0000, 32'h0000_0000, 1'b1},
    '{1'b1, OFF_DELAY, 32'h1234_5678, 32'h0000_0000, 1'b0},
    '{1'b0, OFF_DELAY, 32'h0000_0000, 32'h0000_5678, 1'b0}
  };

  // small rx depth so the counts stay short
  packet_fifo_level_tracking #(.RX_AW(4), .TX_AW(11)) i_packet_fifo_level_tracking (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_wr_valid(rx_wr_valid), .rx_wr_data(rx_wr_data),
    .rx_wr_last(rx_wr_last), .rx_fcs_bad(rx_fcs_bad), .rx_wr_ready(rx_wr_ready),
    .rx_rd_valid(rx_rd_valid), .rx_rd_data(rx_rd_data), .rx_rd_last(rx_rd_last),
    .rx_rd_ready(rx_rd_ready), .usb_rewind(usb_rewind), .tx_wr_dword(tx_wr_dword),
    .tx_wr_last(tx_wr_last), .tx_wr_rewind(tx_wr_rewind), .tx_rd_dword(tx_rd_dword),
    .tx_rd_last(tx_rd_last), .short_req(short_req), .short_go(short_go));

  mac_usb_model i_mac_usb_model (
    .pclk(pclk), .presetn(presetn), .rx_wr_valid(rx_wr_valid), .rx_wr_data(rx_wr_data),
    .rx_wr_last(rx_wr_last), .rx_wr_ready(rx_wr_ready), .rx_rd_valid(rx_rd_valid),
    .rx_rd_data(rx_rd_data), .rx_rd_last(rx_rd_last), .rx_rd_ready(rx_rd_ready),
    .usb_stall(usb_stall));

  always #4 pclk = ~pclk;

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer; an edge passes afterwards so a new setup never lands in the same step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk(r, exp);
  endtask

  task automatic run_rows(input int lo, input int hi);
    logic [31:0] r;
    logic e;
    for (int i = lo; i <= hi; i++) begin
      apb(rows[i].wr, rows[i].a, rows[i].d, r, e);
      chk(32'(e), 32'(rows[i].err));
      if (!rows[i].wr) chk(r, rows[i].rd);
    end
  endtask

  // expected wait is the delay in 16.667 ns units rounded up to clocks, plus two
  task automatic short_run(input int d);
    logic [31:0] r;
    logic e;
    int n;
    int exp;
    exp = (d * UNIT_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS + 2;
    apb(1'b1, OFF_DELAY, 32'(d), r, e);
    short_req <= 1'b1;
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (short_go !== 1'b1 && n < 1000);
    chk(32'(n >= exp - 2 && n <= exp + 2), 32'h0000_0001);
    @(posedge pclk);
    short_req <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic txp(input logic [4:0] v);
    {tx_wr_dword, tx_wr_last, tx_wr_rewind, tx_rd_dword, tx_rd_last} <= v;
    @(posedge pclk);
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {rx_fcs_bad, usb_rewind, short_req} = '0;
    {tx_wr_dword, tx_wr_last, tx_wr_rewind, tx_rd_dword, tx_rd_last} = '0;
    usb_stall = 1'b1;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    run_rows(0, 8);
    $display("test registers done");
    short_run(0);
    short_run(6);
    short_run(240);
    $display("test short delay done");
    // usb stalls: two words sit in the buffer, one stays counted in the store
    i_mac_usb_model.send(3, 1'b1);
    repeat (8) @(posedge pclk);
    rd_chk(OFF_RX_LVL, 32'h0001_0003);
    rd_chk(OFF_RX_PTR, 32'h0002_0003);
    usb_rewind <= 1'b1;
    @(posedge pclk);
    usb_rewind <= 1'b0;
    repeat (4) @(posedge pclk);
    usb_stall <= 1'b0;
    repeat (12) @(posedge pclk);
    chk(32'(i_mac_usb_model.got.size()), 32'h0000_0003);
    foreach (i_mac_usb_model.got[i]) begin
      chk(i_mac_usb_model.got[i][31:0], 32'hc0de_0000 + 32'(i));
      chk(32'(i_mac_usb_model.got[i][32]), 32'(i == 2));
    end
    rd_chk(OFF_RX_LVL, 32'h0000_0000);
    rd_chk(OFF_RX_PTR, 32'h0003_0003);
    i_mac_usb_model.send(2, 1'b0);
    repeat (2) @(posedge pclk);
    rd_chk(OFF_RX_LVL, 32'h0000_0002);
    rx_fcs_bad <= 1'b1;
    @(negedge pclk);
    chk(32'(rx_wr_ready), 32'h0000_0000);
    @(posedge pclk);
    rx_fcs_bad <= 1'b0;
    repeat (2) @(posedge pclk);
    rd_chk(OFF_RX_LVL, 32'h0000_0000);
    rd_chk(OFF_RX_PTR, 32'h0003_0003);
    $display("test rx fifo done");
    txp(5'b10000);
    txp(5'b10000);
    txp(5'b11000);
    txp(5'b10000);
    txp(5'b10000);
    txp(5'b00000);
    rd_chk(OFF_TX_LVL, 32'h0003_0005);
    txp(5'b00100);
    txp(5'b00010);
    txp(5'b00010);
    txp(5'b00000);
    rd_chk(OFF_TX_LVL, 32'h0001_0003);
    txp(5'b00100);
    txp(5'b00000);
    rd_chk(OFF_TX_LVL, 32'h0001_0003);
    txp(5'b00011);
    txp(5'b00000);
    rd_chk(OFF_TX_LVL, 32'h0000_0000);
    $display("test tx fifo done");
    // leave the write levels and the rx pointers non-zero so the reset has something to clear
    i_mac_usb_model.send(2, 1'b0);
    txp(5'b10000);
    txp(5'b00000);
    rd_chk(OFF_RX_LVL, 32'h0000_0002);
    rd_chk(OFF_TX_LVL, 32'h0000_0001);
    // a second reset in mid-run restores the delay and clears the status
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    run_rows(0, 3);
    $display("test second reset done");
    give_verdict();
  end
endmodule
`default_nettype wire
